// file: inc/tbc_pkg.sv
// Purpose: Shared constants for the timebase counter with input capture.
// Assumes: Avalon-MM word addressing, 32-bit data, one system clock.
// Notes: Offsets are word indexes; byte address is four times the index.
package tbc_pkg;
  // Geometry
  localparam int NCH = 2;
  localparam int CW = 16;
  localparam int AW = 4;
  // Register word indexes
  localparam logic [AW-1:0] OFS_STATUS_CTRL = 4'h0;
  localparam logic [AW-1:0] OFS_COUNTER = 4'h1;
  localparam logic [AW-1:0] OFS_FINAL = 4'h2;
  localparam logic [AW-1:0] OFS_INITIAL = 4'h3;
  localparam logic [AW-1:0] OFS_CONFIG = 4'h4;
  localparam logic [AW-1:0] OFS_CH_CTRL0 = 4'h8;
  localparam logic [AW-1:0] OFS_CH_VALUE0 = 4'h9;
  // Status/control field positions
  localparam int SC_CLKSEL_LSB = 0;
  localparam int SC_PRESCALE_LSB = 2;
  localparam int SC_UPDOWN_BIT = 5;
  localparam int SC_OVF_BIT = 6;
  // Config field positions
  localparam int CF_ENH_BIT = 0;
  localparam int CF_SKIP_LSB = 1;
  localparam int CF_DUALCAP_BIT = 6;
  localparam int CF_COMBINE_BIT = 7;
  // Channel control field positions
  localparam int CC_EDGE_LSB = 0;
  localparam int CC_MODE_LSB = 2;
  localparam int CC_IE_BIT = 4;
  localparam int CC_FLAG_BIT = 5;
  // Clock source selections
  localparam logic [1:0] CLK_NONE = 2'h0;
  localparam logic [1:0] CLK_SYSTEM = 2'h1;
  localparam logic [1:0] CLK_FIXED = 2'h2;
  localparam logic [1:0] CLK_EXTERNAL = 2'h3;
  // Edge selections
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  // Counter values and reset values
  localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CW-1:0] CNT_ALL = 16'hFFFF;
  localparam logic [CW-1:0] CNT_ONE = 16'h0001;
  localparam logic [4:0] SKIP_ZERO = 5'h00;
  localparam logic [4:0] SKIP_ONE = 5'h01;
  localparam logic [6:0] PRE_ZERO = 7'h00;
  localparam logic [6:0] PRE_ONE = 7'h01;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage : tbc_pkg

// file: hdl/sync_edge.sv
// Purpose: Two-stage synchronizer followed by an edge detector.
// Assumes: Input may be asynchronous to mclk.
// Notes: Edge outputs are combinational from flops, one cycle wide.
`timescale 1ns/1ps
module sync_edge (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Raw input
  input wire logic din,
  // Detected edges
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_state_t;

  sync_state_t st_q, st_d;

  // Shift chain; s1 feeds only s2 to keep metastability contained
  always_comb begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Edge compare on the settled stages only
  assign rise = st_q.s2 & ~st_q.s3;
  assign fall = ~st_q.s2 & st_q.s3;
endmodule : sync_edge

// file: hdl/prescaler7.sv
// Purpose: Seven-bit prescaler dividing a tick stream by 2**sel.
// Assumes: srcTick is a one-cycle enable in the mclk domain.
// Notes: clear restarts the division phase.
`timescale 1ns/1ps
module prescaler7 (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Control
  input wire logic srcTick,
  input wire logic [2:0] sel,
  input wire logic clear,
  // Divided tick
  output logic tick
);
  import tbc_pkg::*;

  typedef struct packed {
    logic [6:0] cnt;
  } pre_state_t;

  pre_state_t st_q, st_d;
  logic [6:0] mask;

  // ratio is two to the select
  // Terminal count mask for ratio 2**sel
  assign mask = 7'((8'h01 << sel) - 8'h01);
  assign tick = srcTick && ((st_q.cnt & mask) == mask);

  // Free counting prescaler; low bits roll over at the chosen ratio
  always_comb begin
    st_d = st_q;
    if (clear) begin
      st_d.cnt = PRE_ZERO;
    end else if (srcTick) begin
      st_d.cnt = st_q.cnt + PRE_ONE;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : prescaler7

// file: hdl/timebase_counter_capture.sv
// Purpose: Timer timebase with prescaler, 16-bit counter and input capture.
// Assumes: Avalon-MM slave with waitrequest, word addressed, 32-bit data.
// Notes: Each access answers with waitrequest low one cycle after request.
//
// Contract
// - Two-bit clock select picks one of three sources or off; resets off.
// - Clock select always accessible; zero stops counter keeping all values.
// - External clock is synchronized; it must stay at most mclk/4.
// - Selected clock passes a 7-bit prescaler chosen by three-bit field.
// - One 16-bit counter shared by channels, clocked by prescaled clock.
// - Up mode counts initial to final then reloads initial.
// - Up mode sets overflow when counter goes final to initial.
// - Initial value bit 15 set means signed two's-complement counting.
// - Final equal to initial holds counter and flags overflow each tick.
// - Enhanced mode with both values zero keeps counter stopped at zero.
// - Up-down mode counts up to final, down to initial, repeating.
// - Up-down mode sets overflow stepping from final to final minus one.
// - Free running 0 to FFFF with overflow on wrap in listed cases.
// - Counter write or sync loads initial value into the counter.
// - Five-bit skip count sets overflows per flag; zero flags each one.
// - Capture mode needs no dual, combine, updown, mode zero, edge nonzero.
// - Selected edge copies counter to value, sets flag, raises interrupt.
// - Value register writes are ignored while in capture mode.
// - Debug freezes counter but capture still works on frozen value.
// - Input passes two-stage sync and edge detect; flag on third edge.
`timescale 1ns/1ps
module timebase_counter_capture (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [tbc_pkg::AW-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Clock sources and system control
  input wire logic fixedClkTick,
  input wire logic extClkPin,
  input wire logic counterSync,
  input wire logic debugMode,
  // Channels
  input wire logic [tbc_pkg::NCH-1:0] channelPin,
  output logic [tbc_pkg::NCH-1:0] channelIrq,
  // Overflow flag view
  output logic overflowFlag
);
  import tbc_pkg::*;

  typedef struct packed {
    logic waitReq;
    logic [31:0] rdata;
    logic [1:0] clkSel;
    logic [2:0] prescaleSel;
    logic updown;
    logic ovfFlag;
    logic enhanced;
    logic [4:0] skipCount;
    logic dualCap;
    logic combine;
    logic [CW-1:0] initVal;
    logic [CW-1:0] finalVal;
    logic [CW-1:0] count;
    logic countDown;
    logic [4:0] ovfSeen;
    logic [NCH-1:0][1:0] edgeSel;
    logic [NCH-1:0][1:0] modeSel;
    logic [NCH-1:0] chIe;
    logic [NCH-1:0] chFlag;
    logic [NCH-1:0][CW-1:0] chValue;
    logic [NCH-1:0] chIrq;
  } top_state_t;

  top_state_t st_q, st_d;

  logic extRise;
  logic srcTick;
  logic cntTick;
  logic [NCH-1:0] pinRise;
  logic [NCH-1:0] pinFall;
  logic [NCH-1:0] chCapMode;
  logic [NCH-1:0] chEdgeHit;
  logic commit;
  logic wrCounter;

  sync_edge u_ext_sync (
    .mclk(mclk),
    .nrst(nrst),
    .din(extClkPin),
    .rise(extRise),
    .fall()
  );

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      sync_edge u_ch_sync (
        .mclk(mclk),
        .nrst(nrst),
        .din(channelPin[gi]),
        .rise(pinRise[gi]),
        .fall(pinFall[gi])
      );
      assign chCapMode[gi] = !st_q.dualCap && !st_q.combine &&
                             !st_q.updown && (st_q.modeSel[gi] == 2'h0) &&
                             (st_q.edgeSel[gi] != EDGE_OFF);
      assign chEdgeHit[gi] = chCapMode[gi] &&
        ((st_q.edgeSel[gi][0] && pinRise[gi]) ||
         (st_q.edgeSel[gi][1] && pinFall[gi]));
    end
  endgenerate

  always_comb begin
    case (st_q.clkSel)
      CLK_SYSTEM: srcTick = 1'b1;
      CLK_FIXED: srcTick = fixedClkTick;
      CLK_EXTERNAL: srcTick = extRise;
      default: srcTick = 1'b0;
    endcase
  end

  // A bus write commits at the edge where waitrequest is seen low
  assign commit = !st_q.waitReq && (read || write);
  assign wrCounter = commit && write && (address == OFS_COUNTER);

  prescaler7 u_pre (
    .mclk(mclk),
    .nrst(nrst),
    .srcTick(srcTick),
    .sel(st_q.prescaleSel),
    .clear(wrCounter),
    .tick(cntTick)
  );

  // Counter mode terms; equality tests keep signed starts correct
  logic freeRun;
  logic stopped;
  logic ovfEvent;
  logic [CW-1:0] nextCount;
  logic nextDown;
  logic [31:0] rdMux;

  // Counter next-state; only called on a prescaled tick
  always_comb begin
    nextCount = st_q.count;
    nextDown = st_q.countDown;
    ovfEvent = 1'b0;
    freeRun = (!st_q.enhanced &&
               (st_q.finalVal == CNT_ZERO || st_q.finalVal == CNT_ALL)) ||
              (st_q.enhanced && !st_q.updown &&
               st_q.initVal == CNT_ZERO && st_q.finalVal == CNT_ALL);
    stopped = st_q.enhanced && st_q.initVal == CNT_ZERO &&
              st_q.finalVal == CNT_ZERO;
    // Priority: stopped, free run, equal values, then the count modes;
    // free run outranks equal values so a zero final wraps through FFFF
    if (stopped) begin
      nextCount = CNT_ZERO;
    end else if (freeRun) begin
      nextCount = st_q.count + CNT_ONE;
      ovfEvent = (st_q.count == CNT_ALL);
    end else if (st_q.finalVal == st_q.initVal) begin
      nextCount = st_q.finalVal;
      ovfEvent = 1'b1;
    end else if (!st_q.updown) begin
      // wraps through 0xFFFF when start is negative
      if (st_q.count == st_q.finalVal) begin
        nextCount = st_q.initVal;
        ovfEvent = 1'b1;
      end else begin
        nextCount = st_q.count + CNT_ONE;
      end
    end else if (!st_q.countDown) begin
      if (st_q.count == st_q.finalVal) begin
        nextCount = st_q.count - CNT_ONE;
        nextDown = 1'b1;
        ovfEvent = 1'b1;
      end else begin
        nextCount = st_q.count + CNT_ONE;
      end
    end else begin
      if (st_q.count == st_q.initVal) begin
        nextCount = st_q.count + CNT_ONE;
        nextDown = 1'b0;
      end else begin
        nextCount = st_q.count - CNT_ONE;
      end
    end
  end

  // Read mux over the register map
  always_comb begin
    rdMux = RD_ZERO;
    // Channel words interleave: control at even, value at odd index;
    // unmapped words read as zero
    case (address)
      OFS_STATUS_CTRL: begin
        rdMux[SC_CLKSEL_LSB +: 2] = st_q.clkSel;
        rdMux[SC_PRESCALE_LSB +: 3] = st_q.prescaleSel;
        rdMux[SC_UPDOWN_BIT] = st_q.updown;
        rdMux[SC_OVF_BIT] = st_q.ovfFlag;
      end
      OFS_COUNTER: rdMux[CW-1:0] = st_q.count;
      OFS_FINAL: rdMux[CW-1:0] = st_q.finalVal;
      OFS_INITIAL: rdMux[CW-1:0] = st_q.initVal;
      OFS_CONFIG: begin
        rdMux[CF_ENH_BIT] = st_q.enhanced;
        rdMux[CF_SKIP_LSB +: 5] = st_q.skipCount;
        rdMux[CF_DUALCAP_BIT] = st_q.dualCap;
        rdMux[CF_COMBINE_BIT] = st_q.combine;
      end
      default: begin
        for (int i = 0; i < NCH; i++) begin
          if (address == AW'(OFS_CH_CTRL0 + 2 * i)) begin
            rdMux[CC_EDGE_LSB +: 2] = st_q.edgeSel[i];
            rdMux[CC_MODE_LSB +: 2] = st_q.modeSel[i];
            rdMux[CC_IE_BIT] = st_q.chIe[i];
            rdMux[CC_FLAG_BIT] = st_q.chFlag[i];
          end
          if (address == AW'(OFS_CH_VALUE0 + 2 * i)) begin
            rdMux[CW-1:0] = st_q.chValue[i];
          end
        end
      end
    endcase
  end

  // Main state update: bus, counter, overflow and capture
  always_comb begin
    st_d = st_q;
    // Handshake: one wait cycle, then one cycle with waitrequest low
    if ((read || write) && st_q.waitReq) begin
      st_d.waitReq = 1'b0;
      st_d.rdata = rdMux;
    end else begin
      st_d.waitReq = 1'b1;
    end

    // Software writes; flags cleared here may be re-set below
    if (commit && write) begin
      case (address)
        OFS_STATUS_CTRL: begin
          st_d.clkSel = writedata[SC_CLKSEL_LSB +: 2];
          st_d.prescaleSel = writedata[SC_PRESCALE_LSB +: 3];
          st_d.updown = writedata[SC_UPDOWN_BIT];
          if (writedata[SC_OVF_BIT]) begin
            st_d.ovfFlag = 1'b0;
          end
        end
        OFS_FINAL: st_d.finalVal = writedata[CW-1:0];
        OFS_INITIAL: st_d.initVal = writedata[CW-1:0];
        OFS_CONFIG: begin
          st_d.enhanced = writedata[CF_ENH_BIT];
          st_d.skipCount = writedata[CF_SKIP_LSB +: 5];
          st_d.dualCap = writedata[CF_DUALCAP_BIT];
          st_d.combine = writedata[CF_COMBINE_BIT];
        end
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (address == AW'(OFS_CH_CTRL0 + 2 * i)) begin
              st_d.edgeSel[i] = writedata[CC_EDGE_LSB +: 2];
              st_d.modeSel[i] = writedata[CC_MODE_LSB +: 2];
              st_d.chIe[i] = writedata[CC_IE_BIT];
              if (writedata[CC_FLAG_BIT]) begin
                st_d.chFlag[i] = 1'b0;
              end
            end
            if (address == AW'(OFS_CH_VALUE0 + 2 * i) && !chCapMode[i]) begin
              st_d.chValue[i] = writedata[CW-1:0];
            end
          end
        end
      endcase
    end

    if (wrCounter || counterSync) begin
      st_d.count = st_q.initVal;
      st_d.countDown = 1'b0;
      st_d.ovfSeen = SKIP_ZERO;
    end else if (cntTick && !debugMode) begin
      st_d.count = nextCount;
      st_d.countDown = nextDown;
      if (ovfEvent) begin
        if (st_q.ovfSeen >= st_q.skipCount) begin
          st_d.ovfSeen = SKIP_ZERO;
          st_d.ovfFlag = 1'b1;
        end else begin
          st_d.ovfSeen = st_q.ovfSeen + SKIP_ONE;
        end
      end
    end

    // Capture takes the registered count, so a reload or tick in this
    // cycle never leaks into the stored channel value
    // capture counter, set flag
    for (int i = 0; i < NCH; i++) begin
      if (chEdgeHit[i]) begin
        st_d.chValue[i] = st_q.count;
        st_d.chFlag[i] = 1'b1;
      end
      st_d.chIrq[i] = st_d.chFlag[i] && st_d.chIe[i];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
      st_q.waitReq <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign readdata = st_q.rdata;
  assign waitrequest = st_q.waitReq;
  assign channelIrq = st_q.chIrq;
  assign overflowFlag = st_q.ovfFlag;
endmodule : timebase_counter_capture

// file: bench/tbc_props.sv
// Purpose: Port-level checks for the timebase counter with capture.
// Assumes: One mclk domain, nrst asynchronous and active low.
// Notes: Clock select is shadowed from bus writes to know when it stops.
`timescale 1ns/1ps
module tbc_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register bus
  input wire logic [tbc_pkg::AW-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Sources and channels
  input wire logic fixedClkTick,
  input wire logic extClkPin,
  input wire logic counterSync,
  input wire logic debugMode,
  input wire logic [tbc_pkg::NCH-1:0] channelPin,
  input wire logic [tbc_pkg::NCH-1:0] channelIrq,
  input wire logic overflowFlag
);
  import tbc_pkg::*;
  logic [1:0] clkSel_q;
  logic [2:0] stopCnt_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Cycles the counter has stood still; slack covers the tick pipeline
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clkSel_q <= CLK_NONE;
      stopCnt_q <= 3'h0;
    end else begin
      if (write && !waitrequest && address == OFS_STATUS_CTRL)
        clkSel_q <= writedata[1:0];
      if (clkSel_q != CLK_NONE && !debugMode) stopCnt_q <= 3'h0;
      else if (stopCnt_q != 3'h7) stopCnt_q <= stopCnt_q + 3'h1;
    end
  end
  property p_accept;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_accept: assert property (p_accept) else $error("no answer");
  property p_oneshot;
    !waitrequest |=> waitrequest;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("long answer");
  property p_idle;
    waitrequest && !read && !write |=> waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("answer unasked");
  property p_upper;
    !waitrequest && read |-> readdata[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_stop;
    $rose(overflowFlag) |-> stopCnt_q < 3'h5;
  endproperty
  a_stop: assert property (p_stop) else $error("halted ovf");
  property p_ovf_clear;
    $fell(overflowFlag) |-> $past(write) && $past(address) == OFS_STATUS_CTRL;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("flag lost");
  property p_irq_delay(int i);
    $rose(channelIrq[i]) && $past(waitrequest) |->
      $past(channelPin[i], 3) != $past(channelPin[i], 4);
  endproperty
  property p_irq_fall(int i);
    $fell(channelIrq[i]) |-> $past(write);
  endproperty
  // Each channel gets its own pair of checks
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    a_irq_delay: assert property (p_irq_delay(g)) else $error("irq");
    a_irq_fall: assert property (p_irq_fall(g)) else $error("drop");
  end
  c_write: cover property (write && !waitrequest);
  c_ovf: cover property ($rose(overflowFlag));
  c_irq: cover property ($rose(channelIrq[0]));
endmodule : tbc_checker

bind timebase_counter_capture tbc_checker u_chk (.mclk, .nrst, .address,
  .read, .write, .writedata, .readdata, .waitrequest, .fixedClkTick,
  .extClkPin, .counterSync, .debugMode, .channelPin, .channelIrq,
  .overflowFlag);

// file: bench/tbc_partner.sv
// Purpose: Far side of the block: external clock and channel inputs.
// Assumes: Commands come from the bench in the mclk domain.
// Notes: External clock stands low while not running.
`timescale 1ns/1ps
module tbc_partner (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Commands
  input wire logic extRun,
  input wire logic [tbc_pkg::NCH-1:0] pinWant,
  // Pins
  output logic extClkPin,
  output logic [tbc_pkg::NCH-1:0] channelPin
);
  logic [1:0] ph_q;
  logic [1:0] gap_q;
  // paced inputs
  // Period four mclk and pin gaps of four keep sampling sound
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ph_q <= 2'h0;
      gap_q <= 2'h0;
      extClkPin <= 1'h0;
      channelPin <= '0;
    end else begin
      ph_q <= extRun ? ph_q + 2'h1 : 2'h0;
      extClkPin <= extRun & ph_q[1];
      if (gap_q != 2'h0) gap_q <= gap_q - 2'h1;
      else if (pinWant != channelPin) begin
        channelPin <= pinWant;
        gap_q <= 2'h3;
      end
    end
  end
endmodule : tbc_partner

// file: bench/timebase_counter_capture_test.sv
// Purpose: Self-checking bench for the timebase counter with capture.
// Assumes: Counter ticks come from the fixed tick or the paced external clock so counts are exact.
// Notes: Random cases use seed 65; corner cases precede them.
`timescale 1ns/1ps
module timebase_counter_capture_test;
  import tbc_pkg::*;
  logic mclk, nrst, read, write, waitrequest, fixedClkTick, extClkPin;
  logic counterSync, debugMode, overflowFlag, extRun, capM;
  logic [AW-1:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [NCH-1:0] channelPin, channelIrq, pinWant;
  logic [15:0] ri;
  logic [15:0] vExp [NCH];
  logic [1:0] eSel;
  int bad_count, tests_run, ch;

  // Device and far-side model
  timebase_counter_capture u_dut (.mclk, .nrst, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .fixedClkTick, .extClkPin,
    .counterSync, .debugMode, .channelPin, .channelIrq, .overflowFlag);
  tbc_partner u_src (.mclk, .nrst, .extRun, .pinWant, .extClkPin,
    .channelPin);

  // 100 MHz system clock
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  task conclude();
    $display("Counts: %0d compared, %0d wrong", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Bus access; the request is held until waitrequest is seen low
  task access(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'h0);
    rd = readdata;
    write <= 1'h0;
    read <= 1'h0;
    @(posedge mclk);
  endtask : access

  task ticks(input int k);
    repeat (k) begin
      fixedClkTick <= 1'h1;
      @(posedge mclk);
      fixedClkTick <= 1'h0;
      repeat (3) @(posedge mclk);
    end
  endtask : ticks

  // One counter tick: {down, overflow, count}
  function automatic logic [17:0] nxt(logic [17:0] s, logic ud, logic enh,
      logic [15:0] ini, logic [15:0] fin);
    logic [15:0] c;
    c = s[15:0];
    if (enh && ini == CNT_ZERO && fin == CNT_ZERO) return {2'h0, c};
    if ((!enh && (fin == CNT_ZERO || fin == CNT_ALL)) ||
        (enh && !ud && ini == CNT_ZERO && fin == CNT_ALL))
      return {1'h0, c == CNT_ALL, c + CNT_ONE};
    if (!ud || fin == ini)
      return (c == fin) ? {2'h1, ini} : {2'h0, c + CNT_ONE};
    if (!s[17]) return (c == fin) ? {2'h3, c - CNT_ONE} : {2'h0, c + CNT_ONE};
    return (c == ini) ? {2'h0, c + CNT_ONE} : {2'h2, c - CNT_ONE};
  endfunction : nxt

  task run_case(input logic ud, input logic enh, input logic [15:0] ini,
      input logic [15:0] fin, input logic [4:0] skip, input logic [2:0] pre,
      input logic [1:0] src, input int n);
    logic [17:0] s;
    int ov;
    s = {2'h0, ini};
    ov = 0;
    repeat (n) begin
      s = nxt(s, ud, enh, ini, fin);
      ov += s[16];
    end
    access(1'h1, OFS_CONFIG, {26'h0, skip, enh});
    access(1'h1, OFS_FINAL, {16'h0, fin});
    access(1'h1, OFS_INITIAL, {16'h0, ini});
    access(1'h1, OFS_STATUS_CTRL, {25'h0, 1'h1, ud, pre, src});
    access(1'h1, OFS_COUNTER, RD_ZERO);
    if (src == CLK_EXTERNAL) begin
      extRun <= 1'h1;
      repeat (4 * n) @(posedge mclk);
      extRun <= 1'h0;
    end else ticks(n << pre);
    repeat (8) @(posedge mclk);
    access(1'h0, OFS_COUNTER, RD_ZERO);
    check(rd, {16'h0, s[15:0]});
    check(32'(overflowFlag), 32'(ov > skip));
    access(1'h1, OFS_STATUS_CTRL, {26'h0, ud, pre, CLK_NONE});
    ticks(3);
    access(1'h0, OFS_COUNTER, RD_ZERO);
    check(rd, {16'h0, s[15:0]});
    counterSync <= 1'h1;
    @(posedge mclk);
    counterSync <= 1'h0;
    @(posedge mclk);
    access(1'h0, OFS_COUNTER, RD_ZERO);
    check(rd, {16'h0, ini});
    $display("test count %h..%h done", ini, fin);
  endtask : run_case

  // Watchdog well past the expected run length
  initial begin
    #400000;
    bad_count++;
    conclude();
  end

  // Main sequence
  initial begin
    nrst = 1'h0;
    {read, write, fixedClkTick, counterSync, debugMode, extRun} = '0;
    address = '0;
    writedata = '0;
    pinWant = '0;
    vExp = '{default: '0};
    bad_count = 0;
    tests_run = 0;
    void'($urandom(65));
    repeat (20) @(posedge mclk);
    nrst <= 1'h1;
    @(posedge mclk);
    access(1'h0, OFS_STATUS_CTRL, RD_ZERO);
    check(rd, RD_ZERO);
    access(1'h0, 4'h5, RD_ZERO);
    check(rd, RD_ZERO);
    $display("test reset done");
    run_case(1'h0, 1'h0, 16'hFFFC, 16'h0004, SKIP_ZERO, 3'h0, CLK_FIXED, 12);
    run_case(1'h0, 1'h0, 16'h0123, 16'h0123, SKIP_ZERO, 3'h1, CLK_FIXED, 3);
    run_case(1'h0, 1'h1, CNT_ZERO, CNT_ZERO, SKIP_ZERO, 3'h0, CLK_FIXED, 4);
    run_case(1'h0, 1'h0, CNT_ZERO, CNT_ZERO, SKIP_ZERO, 3'h0, CLK_FIXED, 5);
    run_case(1'h1, 1'h0, 16'h0010, 16'h0013, 5'h01, 3'h0, CLK_FIXED, 14);
    run_case(1'h0, 1'h0, 16'h0002, 16'h0004, 5'h1F, 3'h7, CLK_FIXED, 2);
    run_case(1'h0, 1'h0, CNT_ZERO, 16'h0005, SKIP_ZERO, 3'h0, CLK_EXTERNAL, 9);
    for (int i = 0; i < 10; i++) begin
      ri = 16'($urandom_range(0, 16'h7FF0));
      run_case(1'($urandom_range(0, 1)), 1'($urandom_range(0, 1)), ri,
        ri + 16'($urandom_range(1, 6)), 5'($urandom_range(0, 3)),
        3'($urandom_range(0, 2)), CLK_FIXED, $urandom_range(1, 20));
    end
    // Capture rounds: edge codes, masking, a compare channel, debug,
    // then dual capture and combine, which both block capture
    access(1'h1, OFS_STATUS_CTRL, RD_ZERO);
    for (int r = 0; r < 8; r++) begin
      ch = r % 2;
      eSel = (r == 4 || r > 5) ? EDGE_RISE : ((r == 5) ? 2'h3 : 2'(r));
      capM = r != 4 && r < 6 && eSel != EDGE_OFF;
      if (r > 5) begin
        access(1'h1, OFS_CONFIG,
          32'h1 << ((r == 6) ? CF_DUALCAP_BIT : CF_COMBINE_BIT));
      end
      ri = 16'($urandom);
      access(1'h1, OFS_INITIAL, {16'h0, ri});
      access(1'h1, OFS_COUNTER, RD_ZERO);
      if (r == 5) begin
        debugMode <= 1'h1;
        access(1'h1, OFS_STATUS_CTRL, {30'h0, CLK_SYSTEM});
      end
      access(1'h1, OFS_CH_CTRL0 + 4'(2 * ch),
        {26'h0, 1'h1, 1'(r != 3), 2'(r == 4), eSel});
      access(1'h1, OFS_CH_VALUE0 + 4'(2 * ch), {16'h0, ~ri});
      if (!capM) vExp[ch] = ~ri;
      pinWant[ch] <= 1'h1;
      repeat (10) @(posedge mclk);
      access(1'h0, OFS_CH_CTRL0 + 4'(2 * ch), RD_ZERO);
      check(32'(rd[5]), 32'(capM & eSel[0]));
      pinWant[ch] <= 1'h0;
      repeat (10) @(posedge mclk);
      access(1'h0, OFS_CH_CTRL0 + 4'(2 * ch), RD_ZERO);
      check(32'(rd[5]), 32'(capM));
      check(32'(channelIrq[ch]), 32'(capM && r != 3));
      if (capM) vExp[ch] = ri;
      access(1'h0, OFS_CH_VALUE0 + 4'(2 * ch), RD_ZERO);
      check(rd, {16'h0, vExp[ch]});
      debugMode <= 1'h0;
      access(1'h1, OFS_STATUS_CTRL, RD_ZERO);
      $display("test capture round %0d done", r);
    end
    conclude();
  end
endmodule : timebase_counter_capture_test
